// [src/uiv_core.sv]
// USB interrupt vectoring, status flags and resume control.
// Assumes register page accesses are single-cycle strobes on core_clk.
//
// Notes on behaviour
// - Resume request bit forces resume signalling on the data lines.
// - Setting resume sets end-of-suspend flag; software clears it after.
// - Bus activity raises end-of-suspend when timed suspend is still set.
// - Vector table: one 16-bit entry per endpoint plus status entry.
// - Single-vector mode: bits 7..1 writable, bit 0 reads zero.
// - Multi-vector mode: hardware loads vector of top pending interrupt.
// - Bits 7..6 are software table base, 64-byte aligned.
// - Bit 5 tells endpoint transfer versus status-register interrupt.
// - Priority: overrun, iso transfers, other transfers, notifications.
// - Endpoint number in bits 4..1, endpoint 0 highest priority.
// - Status vectoring shows all ones in the endpoint field.
// - Bit 0 of the vector register always reads zero.
// - Any status flag gives status vector; several flags, one interrupt.
// - Mode bit: zero multi-vector, one single-vector.
`timescale 1ns/1ps
module uiv_core
    import uiv_pkg::*;
#(
    parameter int EPS = UIV_EP_COUNT
) (
    input  wire logic           core_clk,
    input  wire logic           sys_rst,
    input  wire logic [7:0]     reg_addr,
    input  wire logic [7:0]     reg_wdata,
    input  wire logic           reg_wr,
    input  wire logic           reg_rd,
    output logic      [7:0]     reg_rdata,
    input  wire logic [EPS-1:0] correct_transfer,
    input  wire logic [EPS-1:0] ep_iso,
    input  wire logic           dma_over_underrun,
    input  wire logic           err_event,
    input  wire logic           susp_event,
    input  wire logic           usb_reset_event,
    input  wire logic           sof_event,
    input  wire logic           esof_event,
    input  wire logic           bus_activity,
    output logic                irq_req,
    output logic                resume_drive,
    output logic                timed_suspend,
    output logic                low_power_suspend,
    output logic                power_down,
    output logic                force_usb_reset
);

    // ------------------------------------------------------------------
    // State and decode
    // ------------------------------------------------------------------
    uiv_state_t st_reg;
    uiv_state_t st_next;

    uiv_arb_if #(.EPS(EPS)) arb_bus ();

    uiv_arbiter #(.EPS(EPS)) u_arb (
        .a (arb_bus.arb)
    );

    logic       wr_vec;
    logic       wr_stat;
    logic       wr_mask;
    logic       wr_ctl;
    logic       rd_vec;
    logic       single_mode;
    logic       wake;
    logic [6:0] stat_set;
    logic [6:0] stat_irq;

    assign wr_vec      = reg_wr && (reg_addr == UIV_ADDR_VECTOR);
    assign wr_stat     = reg_wr && (reg_addr == UIV_ADDR_STATUS);
    assign wr_mask     = reg_wr && (reg_addr == UIV_ADDR_MASK);
    assign wr_ctl      = reg_wr && (reg_addr == UIV_ADDR_CONTROL);
    assign rd_vec      = reg_rd && (reg_addr == UIV_ADDR_VECTOR);
    assign single_mode = st_reg.ctl[UIV_CTL_VECTOR_MODE_SELECT];
    assign wake        = bus_activity && st_reg.ctl[UIV_CTL_TSUSP];
    assign stat_irq    = st_reg.istr & st_reg.imr[6:0];

    always_comb begin
        stat_set                = '0;
        stat_set[UIV_ST_DMA_OVER_UNDERRUN] = dma_over_underrun;
        stat_set[UIV_ST_ERR]    = err_event;
        stat_set[UIV_ST_SUSP]   = susp_event;
        stat_set[UIV_ST_RESET]  = usb_reset_event;
        stat_set[UIV_ST_SOF]    = sof_event;
        stat_set[UIV_ST_ESOF]   = esof_event;
        stat_set[UIV_ST_END_OF_SUSPEND_FLAG] = wake ||
            (st_reg.ctl[UIV_CTL_RESUME] && !st_reg.resume_q);
    end

    assign arb_bus.correct_transfer  = correct_transfer;
    assign arb_bus.ep_iso            = ep_iso;
    assign arb_bus.dma_over_underrun = stat_irq[UIV_ST_DMA_OVER_UNDERRUN];
    assign arb_bus.notify_pend       = |stat_irq[UIV_ST_ERR:UIV_ST_ESOF];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_next          = st_reg;
        st_next.resume_q = st_reg.ctl[UIV_CTL_RESUME];

        // Write zero clears, write one keeps; a new event wins
        if (wr_stat) begin
            st_next.istr = st_reg.istr & reg_wdata[6:0];
        end
        st_next.istr = st_next.istr | stat_set;

        if (wr_mask) begin
            st_next.imr = reg_wdata & UIV_MASK_WMASK;
        end
        if (wr_ctl) begin
            st_next.ctl = reg_wdata & UIV_CTL_WMASK;
        end
        if (wake) begin
            st_next.ctl[UIV_CTL_LPSUSP] = 1'b0;
        end

        if (wr_vec) begin
            if (single_mode) begin
                st_next.vec_sw = reg_wdata[7:1];
            end else begin
                st_next.vec_sw[6:5] = reg_wdata[7:6];
            end
        end

        // Hardware vector, frozen while being read
        if (!rd_vec) begin
            if (arb_bus.hit && arb_bus.is_transfer) begin
                st_next.correct_transfer_pending = 1'b1;
                st_next.vec_ep  = arb_bus.ep_num;
            end else begin
                st_next.correct_transfer_pending = 1'b0;
                st_next.vec_ep  = UIV_EP_STATUS;
            end
        end

        st_next.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                UIV_ADDR_VECTOR: begin
                    if (single_mode) begin
                        st_next.rdata = {st_reg.vec_sw, 1'b0};
                    end else begin
                        st_next.rdata = {st_reg.vec_sw[6:5],
                                         st_reg.correct_transfer_pending,
                                         st_reg.vec_ep, 1'b0};
                    end
                end
                UIV_ADDR_STATUS:  st_next.rdata = {1'b0, st_reg.istr};
                UIV_ADDR_MASK:    st_next.rdata = st_reg.imr;
                UIV_ADDR_CONTROL: st_next.rdata = st_reg.ctl;
                default:          st_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg.vec_sw   <= UIV_VEC_RESET;
            st_reg.correct_transfer_pending <= 1'b0;
            st_reg.vec_ep   <= UIV_EP_STATUS;
            st_reg.istr     <= UIV_STAT_RESET;
            st_reg.imr      <= UIV_MASK_RESET;
            st_reg.ctl      <= UIV_CTL_RESET;
            st_reg.resume_q <= 1'b0;
            st_reg.rdata    <= 8'h00;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata         = st_reg.rdata;
    assign irq_req           = (|stat_irq) || (|correct_transfer);
    assign resume_drive      = st_reg.ctl[UIV_CTL_RESUME];
    assign timed_suspend     = st_reg.ctl[UIV_CTL_TSUSP];
    assign low_power_suspend = st_reg.ctl[UIV_CTL_LPSUSP];
    assign power_down        = st_reg.ctl[UIV_CTL_PDWN];
    assign force_usb_reset   = st_reg.ctl[UIV_CTL_FRES];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_resume_drive_set: assert property (
        wr_ctl && reg_wdata[UIV_CTL_RESUME] |=> resume_drive [*2] or
        (resume_drive ##1 $past(wr_ctl)))
        else $error("resume request did not drive resume");

    a_resume_sets_end_of_suspend_flag: assert property (
        $rose(resume_drive) |=> st_reg.istr[UIV_ST_END_OF_SUSPEND_FLAG])
        else $error("resume did not set end-of-suspend flag");

    a_wake_sets_end_of_suspend_flag: assert property (
        bus_activity && timed_suspend |=>
        st_reg.istr[UIV_ST_END_OF_SUSPEND_FLAG] && !low_power_suspend)
        else $error("bus activity in timed suspend not flagged");

    a_vec_bit_zero: assert property (
        rd_vec |=> reg_rdata[0] == 1'b0)
        else $error("vector bit 0 read as one");

    a_single_write: assert property (
        wr_vec && single_mode |=>
        st_reg.vec_sw == $past(reg_wdata[7:1]))
        else $error("single mode vector bits not stored");

    a_table_base: assert property (
        rd_vec && !single_mode |=>
        reg_rdata[7:6] == $past(st_reg.vec_sw[6:5]))
        else $error("vector table base bits wrong");

    a_status_ones: assert property (
        !st_reg.correct_transfer_pending |-> st_reg.vec_ep == UIV_EP_STATUS)
        else $error("status vector endpoint field not all ones");

    a_overrun_first: assert property (
        stat_irq[UIV_ST_DMA_OVER_UNDERRUN] && !rd_vec |=>
        !st_reg.correct_transfer_pending)
        else $error("overrun did not take priority");

    a_ep0_first: assert property (
        correct_transfer[0] && ep_iso[0] &&
        !stat_irq[UIV_ST_DMA_OVER_UNDERRUN] && !rd_vec
        |=> st_reg.correct_transfer_pending && st_reg.vec_ep == 4'h0)
        else $error("endpoint 0 not given top priority");

    a_vec_stable: assert property (
        rd_vec |=> $stable(st_reg.correct_transfer_pending) &&
        $stable(st_reg.vec_ep))
        else $error("vector changed during read");

    a_one_irq: assert property (
        (|stat_irq) |-> irq_req)
        else $error("status flag did not request interrupt");

endmodule // uiv_core

// [src/uiv_pkg.sv]
// Constants and state types for the USB interrupt vector and resume block.
// Assumes a single core clock and register page access by byte address.
package uiv_pkg;

    // ------------------------------------------------------------------
    // Register addresses within the page
    // ------------------------------------------------------------------
    localparam logic [7:0] UIV_ADDR_VECTOR  = 8'hF8;
    localparam logic [7:0] UIV_ADDR_STATUS  = 8'hF9;
    localparam logic [7:0] UIV_ADDR_MASK    = 8'hFA;
    localparam logic [7:0] UIV_ADDR_CONTROL = 8'hFC;

    // ------------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------------
    localparam logic [7:0] UIV_CTL_RESET  = 8'h15;
    localparam logic [7:0] UIV_CTL_WMASK  = 8'h5F;
    localparam logic [6:0] UIV_STAT_RESET = 7'h00;
    localparam logic [7:0] UIV_MASK_RESET = 8'h00;
    localparam logic [7:0] UIV_MASK_WMASK = 8'h7F;
    localparam logic [6:0] UIV_VEC_RESET  = 7'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int UIV_CTL_FRES   = 0;
    localparam int UIV_CTL_LPSUSP = 1;
    localparam int UIV_CTL_PDWN   = 2;
    localparam int UIV_CTL_RESUME = 3;
    localparam int UIV_CTL_VECTOR_MODE_SELECT = 4;
    localparam int UIV_CTL_TSUSP  = 6;

    localparam int UIV_ST_ESOF  = 0;
    localparam int UIV_ST_SOF   = 1;
    localparam int UIV_ST_RESET = 2;
    localparam int UIV_ST_SUSP  = 3;
    localparam int UIV_ST_END_OF_SUSPEND_FLAG = 4;
    localparam int UIV_ST_ERR   = 5;
    localparam int UIV_ST_DMA_OVER_UNDERRUN = 6;

    localparam int         UIV_EP_COUNT  = 16;
    localparam logic [3:0] UIV_EP_STATUS = 4'hF;

    // ------------------------------------------------------------------
    // Block state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [6:0] vec_sw;
        logic       correct_transfer_pending;
        logic [3:0] vec_ep;
        logic [6:0] istr;
        logic [7:0] imr;
        logic [7:0] ctl;
        logic       resume_q;
        logic [7:0] rdata;
    } uiv_state_t;

endpackage

// [src/uiv_arb_if.sv]
// Carrier between the vector core and the priority arbiter.
// Assumes the arbiter is purely combinational.
`timescale 1ns/1ps
interface uiv_arb_if #(parameter int EPS = 16);
    logic [EPS-1:0] correct_transfer;
    logic [EPS-1:0] ep_iso;
    logic           dma_over_underrun;
    logic           notify_pend;
    logic           hit;
    logic           is_transfer;
    logic [3:0]     ep_num;

    modport arb  (input correct_transfer, ep_iso, dma_over_underrun,
                  notify_pend, output hit, is_transfer, ep_num);
    modport core (output correct_transfer, ep_iso, dma_over_underrun,
                  notify_pend, input hit, is_transfer, ep_num);
endinterface

// [src/uiv_arbiter.sv]
// Priority arbiter for pending USB interrupts.
// Assumes pending inputs are already masked by the caller.
`timescale 1ns/1ps
module uiv_arbiter
    import uiv_pkg::*;
#(
    parameter int EPS = UIV_EP_COUNT
) (
    uiv_arb_if.arb a
);

    // ------------------------------------------------------------------
    // Split endpoints into isochronous and other classes
    // ------------------------------------------------------------------
    logic [EPS-1:0] iso_pend;
    logic [EPS-1:0] non_pend;

    genvar g;
    generate
        for (g = 0; g < EPS; g++) begin : g_split
            assign iso_pend[g] = a.correct_transfer[g] & a.ep_iso[g];
            assign non_pend[g] = a.correct_transfer[g] & ~a.ep_iso[g];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Lowest endpoint number wins within a class
    // ------------------------------------------------------------------
    logic [3:0] iso_num;
    logic [3:0] non_num;

    always_comb begin
        iso_num = UIV_EP_STATUS;
        non_num = UIV_EP_STATUS;
        for (int i = EPS - 1; i >= 0; i--) begin
            if (iso_pend[i]) begin
                iso_num = 4'(i);
            end
            if (non_pend[i]) begin
                non_num = 4'(i);
            end
        end
    end

    // ------------------------------------------------------------------
    // Class order: overrun, iso, non-iso, notification
    // ------------------------------------------------------------------
    always_comb begin
        a.hit         = 1'b1;
        a.is_transfer = 1'b0;
        a.ep_num      = UIV_EP_STATUS;
        if (a.dma_over_underrun) begin
            a.is_transfer = 1'b0;
        end else if (|iso_pend) begin
            a.is_transfer = 1'b1;
            a.ep_num      = iso_num;
        end else if (|non_pend) begin
            a.is_transfer = 1'b1;
            a.ep_num      = non_num;
        end else if (a.notify_pend) begin
            a.is_transfer = 1'b0;
        end else begin
            a.hit = 1'b0;
        end
    end

endmodule // uiv_arbiter

// [sim/uiv_host_model.sv]
// Behavioural host or hub on the far side of the resume logic.
// Assumes one core clock; answers a device resume with bus activity.
`timescale 1ns/1ps
module uiv_host_model #(
    parameter int HOST_DLY = 40
) (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic resume_drive,
    input  wire logic wake_req,
    output logic      bus_activity
);
    logic prev_resume_reg;
    int   dly_reg;

    // ------------------------------------------------------------------
    // Resume answer and host-started wakeup
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_resume_reg <= 1'b0;
            dly_reg         <= 0;
            bus_activity    <= 1'b0;
        end else begin
            prev_resume_reg <= resume_drive;
            bus_activity    <= (dly_reg == 1) || wake_req;
            if (prev_resume_reg && !resume_drive)
                dly_reg <= HOST_DLY;
            else if (dly_reg != 0)
                dly_reg <= dly_reg - 1;
        end
    end
endmodule // uiv_host_model

// [sim/test_usb_irq_vector_and_resume.sv]
// Self-checking bench for the USB interrupt vector and resume core.
// Assumes uiv_pkg, uiv_arb_if, uiv_arbiter and uiv_core compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; \
    if ((g) !== (e)) begin miscompares++; \
    $display("mismatch t=%0t got %0h exp %0h", $time, g, e); end end
module test_usb_irq_vector_and_resume
    import uiv_pkg::*;
;
    localparam int HOST_DLY = 40;
    localparam int RES_HOLD = 200; // Short stand-in for the ms hold
    logic        core_clk    = 1'b0;
    logic        sys_rst     = 1'b1;
    logic [7:0]  reg_addr    = 8'h00;
    logic [7:0]  reg_wdata   = 8'h00;
    logic        reg_wr      = 1'b0;
    logic        reg_rd      = 1'b0;
    logic [15:0] correct_transfer = 16'h0000;
    logic [15:0] ep_iso      = 16'h0000;
    logic [6:0]  evt         = 7'h00;
    logic        wake_req    = 1'b0;
    logic [7:0]  reg_rdata;
    logic        bus_activity, irq_req, resume_drive, timed_suspend;
    logic        low_power_suspend, power_down, force_usb_reset;
    logic [7:0]  rv;
    logic [1:0]  vbase       = 2'b00;
    int          miscompares = 0;
    int          num_checks  = 0;
    int          cycles      = 0;
    int          seed        = 1966;
    int          bl[6]       = '{0, 1, 2, 3, 5, 6};

    always #2.5 core_clk = ~core_clk;

    uiv_core uiv_core_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .correct_transfer(correct_transfer),
        .ep_iso(ep_iso), .dma_over_underrun(evt[6]), .err_event(evt[5]),
        .susp_event(evt[3]), .usb_reset_event(evt[2]),
        .sof_event(evt[1]), .esof_event(evt[0]),
        .bus_activity(bus_activity), .irq_req(irq_req),
        .resume_drive(resume_drive), .timed_suspend(timed_suspend),
        .low_power_suspend(low_power_suspend), .power_down(power_down),
        .force_usb_reset(force_usb_reset));

    uiv_host_model #(.HOST_DLY(HOST_DLY)) uiv_host_model_inst (
        .core_clk(core_clk), .sys_rst(sys_rst),
        .resume_drive(resume_drive), .wake_req(wake_req),
        .bus_activity(bus_activity));

    // ------------------------------------------------------------------
    // Reference model and bus tasks
    // ------------------------------------------------------------------
    function automatic logic [7:0] exp_vec(input logic [15:0] p,
        input logic [15:0] iso, input logic dv, input logic [1:0] base);
        logic [3:0] ep;
        logic       c;
        ep = 4'hF;
        c  = 1'b0;
        for (int k = 31; k >= 0; k--) begin
            if (!dv && p[k % 16] && (iso[k % 16] == (k < 16))) begin
                ep = 4'(k % 16);
                c  = 1'b1;
            end
        end
        return {base, c, ep, 1'b0};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask

    task automatic pulse_wake();
        @(posedge core_clk) wake_req <= 1'b1;
        @(posedge core_clk) wake_req <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1;
        `CHK({power_down, force_usb_reset}, 2'b11)
        rd_chk(UIV_ADDR_CONTROL, UIV_CTL_RESET);
        rd_chk(UIV_ADDR_STATUS, 8'h00);
        rd_chk(UIV_ADDR_MASK, 8'h00);
        rd_chk(UIV_ADDR_VECTOR, 8'h00);
        wr(UIV_ADDR_CONTROL, 8'hFF);
        rd_chk(UIV_ADDR_CONTROL, UIV_CTL_WMASK);
        `CHK(resume_drive, 1'b1)
        wr(8'hFB, 8'hFF);
        rd_chk(8'hFB, 8'h00);
        wr(UIV_ADDR_MASK, 8'hFF);
        rd_chk(UIV_ADDR_MASK, UIV_MASK_WMASK);
        $display("test registers done");
        wr(UIV_ADDR_CONTROL, 8'h10);
        repeat (4) begin
            rv = 8'($random(seed));
            wr(UIV_ADDR_VECTOR, rv);
            @(posedge core_clk) correct_transfer <= 16'($random(seed));
            rd_chk(UIV_ADDR_VECTOR, {rv[7:1], 1'b0});
        end
        wr(UIV_ADDR_CONTROL, 8'h00);
        wr(UIV_ADDR_MASK, 8'h00);
        rd_chk(UIV_ADDR_STATUS, 8'h10);
        wr(UIV_ADDR_STATUS, 8'hEF);
        $display("test single vector done");
        for (int i = 0; i < 24; i++) begin
            rv = 8'($random(seed));
            vbase = rv[7:6];
            wr(UIV_ADDR_VECTOR, rv);
            @(posedge core_clk);
            correct_transfer <= (i == 0) ? 16'h0000
                              : 16'($random(seed) & $random(seed));
            ep_iso      <= 16'($random(seed));
            repeat (2) @(posedge core_clk);
            #1;
            `CHK(irq_req, |correct_transfer)
            rd_chk(UIV_ADDR_VECTOR,
                   exp_vec(correct_transfer, ep_iso, 1'b0, vbase));
        end
        $display("test multi vector done");
        wr(UIV_ADDR_MASK, 8'h7F);
        @(posedge core_clk);
        correct_transfer <= 16'h0030;
        ep_iso      <= 16'h0020;
        foreach (bl[k]) begin
            @(posedge core_clk) evt[bl[k]] <= 1'b1;
            @(posedge core_clk) evt[bl[k]] <= 1'b0;
            rd_chk(UIV_ADDR_STATUS, 8'(1 << bl[k]));
            rd_chk(UIV_ADDR_VECTOR,
                   exp_vec(correct_transfer, ep_iso, bl[k] == 6, vbase));
            wr(UIV_ADDR_STATUS, ~8'(1 << bl[k]));
        end
        @(posedge core_clk) correct_transfer <= 16'h0000;
        @(posedge core_clk) evt <= 7'h41;
        @(posedge core_clk) evt <= 7'h00;
        wr(UIV_ADDR_STATUS, 8'hFF);
        rd_chk(UIV_ADDR_STATUS, 8'h41);
        rd_chk(UIV_ADDR_VECTOR, {vbase, 6'h1E});
        `CHK(irq_req, 1'b1)
        wr(UIV_ADDR_MASK, 8'h00);
        `CHK(irq_req, 1'b0)
        wr(UIV_ADDR_STATUS, 8'hBE);
        rd_chk(UIV_ADDR_STATUS, 8'h00);
        $display("test status vector done");
        wr(UIV_ADDR_CONTROL, 8'h42);
        wr(UIV_ADDR_CONTROL, 8'h40);
        `CHK(timed_suspend, 1'b1)
        `CHK(low_power_suspend, 1'b0)
        wr(UIV_ADDR_CONTROL, 8'h48);
        `CHK(resume_drive, 1'b1)
        repeat (RES_HOLD) @(posedge core_clk);
        rd_chk(UIV_ADDR_STATUS, 8'h10);
        wr(UIV_ADDR_CONTROL, 8'h40);
        `CHK(resume_drive, 1'b0)
        wr(UIV_ADDR_STATUS, 8'hEF);
        rd_chk(UIV_ADDR_STATUS, 8'h00);
        repeat (HOST_DLY + 4) @(posedge core_clk);
        rd_chk(UIV_ADDR_STATUS, 8'h10);
        wr(UIV_ADDR_STATUS, 8'hEF);
        $display("test remote wakeup done");
        wr(UIV_ADDR_CONTROL, 8'h42);
        pulse_wake();
        `CHK(low_power_suspend, 1'b0)
        rd_chk(UIV_ADDR_STATUS, 8'h10);
        wr(UIV_ADDR_STATUS, 8'hEF);
        wr(UIV_ADDR_CONTROL, 8'h02);
        pulse_wake();
        rd_chk(UIV_ADDR_STATUS, 8'h00);
        $display("test host wakeup done");
        tally_and_finish();
    end
endmodule // test_usb_irq_vector_and_resume
